// ### rtl/rtcdt_top.sv
// Clock-calendar time/date value registers and alarm match registers.
// Assumes an APB master on CLK; registers keep state until ARST_N.
module rtcdt_top
    import rtcdt_pkg::*;
#(
    parameter int SEC_LEN = SEC_CYCLES
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // APB request
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    // APB answer
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);

    // ========================================================
    // Decoding helpers
    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] last,
                                           input logic [7:0] first);
        logic [8:0] r;
        r = {1'b0, v};
        if (v == last) begin
            r = {1'b1, first};
        end else if (v[3:0] == 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    function automatic logic is_leap(input logic [7:0] yr);
        logic r;
        // Every year divisible by four in 2000..2099 is a leap year
        r = 1'b0;
        if (!yr[4]) begin
            r = yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8;
        end else begin
            r = yr[3:0] == 4'h2 || yr[3:0] == 4'h6;
        end
        return r;
    endfunction

    function automatic logic [7:0] month_last(input logic [7:0] mon,
                                              input logic leap);
        logic [7:0] r;
        case (mon)
            8'h02: r = leap ? 8'h29 : 8'h28;
            8'h04: r = 8'h30;
            8'h06: r = 8'h30;
            8'h09: r = 8'h30;
            8'h11: r = 8'h30;
            default: r = 8'h31;
        endcase
        return r;
    endfunction

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // ========================================================
    // APB access decode
    logic setup, access, wr_strobe;
    logic hit_ctrl, hit_time, hit_date, hit_atime, hit_adate, hit_key;
    logic hit_any;

    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE && PREADY;
    assign wr_strobe = access && PWRITE;
    assign hit_ctrl = is_addr(PADDR, OFS_CTRL);
    assign hit_time = is_addr(PADDR, OFS_TIME);
    assign hit_date = is_addr(PADDR, OFS_DATE);
    assign hit_atime = is_addr(PADDR, OFS_ALM_TIME);
    assign hit_adate = is_addr(PADDR, OFS_ALM_DATE);
    assign hit_key = is_addr(PADDR, OFS_KEY);
    assign hit_any = hit_ctrl || hit_time || hit_date || hit_atime ||
                     hit_adate || hit_key;

    // ========================================================
    // Unlock and prescaler
    logic armed, sec_tick, half_sec, sync_busy;
    logic ctrl_on, wren;
    logic time_wr;

    rtcdt_unlock u_unlock (
        .clk(CLK),
        .arst_n(ARST_N),
        .key_write(wr_strobe && hit_key),
        .key_data(PWDATA),
        .ctrl_write(wr_strobe && hit_ctrl),
        .other_write(wr_strobe && !hit_key && !hit_ctrl),
        .armed(armed)
    );

    // Writing the time restarts the second, clearing the half flag
    assign time_wr = wr_strobe && hit_time && wren;

    rtcdt_tick #(
        .SEC_LEN(SEC_LEN)
    ) u_tick (
        .clk(CLK),
        .arst_n(ARST_N),
        .run(ctrl_on),
        .clear(time_wr),
        .sec_tick(sec_tick),
        .half_sec(half_sec),
        .sync_busy(sync_busy)
    );

    // ========================================================
    // Control register
    logic next_on, next_wren;

    always_comb begin
        next_on = ctrl_on;
        next_wren = wren;
        if (wr_strobe && hit_ctrl) begin
            next_on = PWDATA[CTRL_ON_BIT];
            if (!PWDATA[CTRL_WREN_BIT]) begin
                next_wren = 1'b0;
            end else if (armed) begin
                next_wren = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_on <= CTRL_RESET[CTRL_ON_BIT];
            wren <= CTRL_RESET[CTRL_WREN_BIT];
        end else begin
            ctrl_on <= next_on;
            wren <= next_wren;
        end
    end

    // ========================================================
    // Time and date counters
    logic [31:0] time_val, date_val, next_time, next_date;
    logic [8:0] s_r, m_r, h_r, w_r, d_r, mo_r, y_r;
    logic leap;

    always_comb begin
        next_time = time_val;
        next_date = date_val;
        leap = is_leap(date_val[YEAR_LSB +: 8]);
        s_r = bcd_inc(time_val[SEC_LSB +: 8], SEC_LAST, BCD_ZERO);
        m_r = bcd_inc(time_val[MIN_LSB +: 8], MIN_LAST, BCD_ZERO);
        h_r = bcd_inc(time_val[HR_LSB +: 8], HR_LAST, BCD_ZERO);
        w_r = bcd_inc({4'h0, date_val[WDAY_LSB +: 4]}, WDAY_LAST,
                      BCD_ZERO);
        d_r = bcd_inc(date_val[MDAY_LSB +: 8],
                      month_last(date_val[MONTH_LSB +: 8], leap),
                      BCD_ONE);
        mo_r = bcd_inc(date_val[MONTH_LSB +: 8], MONTH_LAST, BCD_ONE);
        y_r = bcd_inc(date_val[YEAR_LSB +: 8], YEAR_LAST, BCD_ZERO);
        if (time_wr) begin
            next_time = PWDATA & TIME_MASK;
        end else if (sec_tick) begin
            next_time[SEC_LSB +: 8] = s_r[7:0];
            if (s_r[8]) begin
                next_time[MIN_LSB +: 8] = m_r[7:0];
                if (m_r[8]) begin
                    next_time[HR_LSB +: 8] = h_r[7:0];
                end
            end
        end
        if (wr_strobe && hit_date && wren) begin
            next_date = PWDATA & DATE_MASK;
        end else if (sec_tick && s_r[8] && m_r[8] && h_r[8]) begin
            next_date[WDAY_LSB +: 4] = w_r[3:0];
            next_date[MDAY_LSB +: 8] = d_r[7:0];
            if (d_r[8]) begin
                next_date[MONTH_LSB +: 8] = mo_r[7:0];
                if (mo_r[8]) begin
                    // 2099 wraps back to 2000
                    next_date[YEAR_LSB +: 8] = y_r[7:0];
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            time_val <= TIME_RESET;
            date_val <= DATE_RESET;
        end else begin
            time_val <= next_time;
            date_val <= next_date;
        end
    end

    // ========================================================
    // Alarm match registers
    logic [31:0] alm_time, alm_date, next_atime, next_adate;

    always_comb begin
        next_atime = alm_time;
        next_adate = alm_date;
        if (wr_strobe && hit_atime) begin
            // Masking keeps the always-zero digit bits at zero
            next_atime = PWDATA & ALM_TIME_MASK;
        end
        if (wr_strobe && hit_adate) begin
            next_adate = PWDATA & ALM_DATE_MASK;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            alm_time <= ALM_TIME_RESET;
            alm_date <= ALM_DATE_RESET;
        end else begin
            alm_time <= next_atime;
            alm_date <= next_adate;
        end
    end

    // ========================================================
    // APB answer: one wait-free access phase after each setup
    logic [31:0] next_rdata, ctrl_view;
    logic next_ready, next_err;

    always_comb begin
        ctrl_view = '0;
        ctrl_view[CTRL_ON_BIT] = ctrl_on;
        ctrl_view[CTRL_WREN_BIT] = wren;
        ctrl_view[CTRL_SYNC_BIT] = sync_busy;
        ctrl_view[CTRL_HALF_BIT] = half_sec;
        next_rdata = PRDATA;
        next_ready = setup;
        next_err = setup && !hit_any;
        if (setup) begin
            next_rdata = '0;
            if (!PWRITE) begin
                if (hit_ctrl) begin
                    next_rdata = ctrl_view;
                end else if (hit_time) begin
                    next_rdata = time_val;
                end else if (hit_date) begin
                    next_rdata = date_val;
                end else if (hit_atime) begin
                    next_rdata = alm_time;
                end else if (hit_adate) begin
                    next_rdata = alm_date;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRDATA <= '0;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PRDATA <= next_rdata;
            PREADY <= next_ready;
            PSLVERR <= next_err;
        end
    end

endmodule

// ### rtl/rtcdt_pkg.sv
// Shared constants of the calendar date and alarm register block.
// Assumes a 20 MHz system clock and a 32-bit APB register port.
package rtcdt_pkg;

    // ========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SEC_PERIOD_NS = 1_000_000_000;
    localparam int SEC_CYCLES = SEC_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SYNC_WINDOW_CYCLES = 32;
    localparam int PRESC_W = 25;

    // ========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIME = 8'h10;
    localparam logic [7:0] OFS_DATE = 8'h20;
    localparam logic [7:0] OFS_ALM_TIME = 8'h30;
    localparam logic [7:0] OFS_ALM_DATE = 8'h40;
    localparam logic [7:0] OFS_KEY = 8'h50;

    // ========================================================
    // Control register bit positions
    localparam int CTRL_ON_BIT = 15;
    localparam int CTRL_WREN_BIT = 3;
    localparam int CTRL_SYNC_BIT = 2;
    localparam int CTRL_HALF_BIT = 1;

    // ========================================================
    // Field positions of the value registers
    localparam int HR_LSB = 24;
    localparam int MIN_LSB = 16;
    localparam int SEC_LSB = 8;
    localparam int YEAR_LSB = 24;
    localparam int MONTH_LSB = 16;
    localparam int MDAY_LSB = 8;
    localparam int WDAY_LSB = 0;

    // ========================================================
    // Writable bit masks; all other bits read zero
    localparam logic [31:0] TIME_MASK = 32'h3F7F7F00;
    localparam logic [31:0] DATE_MASK = 32'hFF1F3F07;
    localparam logic [31:0] ALM_TIME_MASK = 32'h3F7F7F00;
    localparam logic [31:0] ALM_DATE_MASK = 32'h001F3F07;

    // ========================================================
    // Values after reset: 00:00:00, 2000-01-01, weekday 0
    localparam logic [31:0] TIME_RESET = 32'h00000000;
    localparam logic [31:0] DATE_RESET = 32'h00010100;
    localparam logic [31:0] ALM_TIME_RESET = 32'h00000000;
    localparam logic [31:0] ALM_DATE_RESET = 32'h00010100;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;

    // ========================================================
    // Unlock key words
    localparam logic [31:0] UNLOCK_KEY1 = 32'hAA996655;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h556699AA;

    // ========================================================
    // BCD wrap points
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HR_LAST = 8'h23;
    localparam logic [7:0] WDAY_LAST = 8'h06;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;

    typedef enum logic [1:0] {
        RTCDT_LOCKED,
        RTCDT_GOT_FIRST,
        RTCDT_ARMED
    } rtcdt_unlock_type;

endpackage

// ### rtl/rtcdt_unlock.sv
// Two-word unlock sequence tracker for the value-register write enable.
// Assumes one-cycle write strobes from the register slave.
module rtcdt_unlock
    import rtcdt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Bus write events
    input wire logic key_write,
    input wire logic [31:0] key_data,
    input wire logic ctrl_write,
    input wire logic other_write,
    // Result
    output logic armed
);

    // ========================================================
    // Sequence state
    rtcdt_unlock_type state, next_state;

    always_comb begin
        next_state = state;
        if (key_write) begin
            if (key_data == UNLOCK_KEY1) begin
                next_state = RTCDT_GOT_FIRST;
            end else if (state == RTCDT_GOT_FIRST &&
                         key_data == UNLOCK_KEY2) begin
                next_state = RTCDT_ARMED;
            end else begin
                next_state = RTCDT_LOCKED;
            end
        end else if (other_write) begin
            // Any foreign write breaks the sequence
            next_state = RTCDT_LOCKED;
        end else if (ctrl_write) begin
            // The control write right after the keys uses the arming
            next_state = RTCDT_LOCKED;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= RTCDT_LOCKED;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        case (state)
            RTCDT_ARMED: armed = 1'b1;
            RTCDT_LOCKED: armed = 1'b0;
            RTCDT_GOT_FIRST: armed = 1'b0;
            default: armed = 1'b0;
        endcase
    end

endmodule

// ### rtl/rtcdt_tick.sv
// Second prescaler: one-second tick, half-second phase, sync window.
// Assumes it runs on the system clock; clear restarts the second.
module rtcdt_tick
    import rtcdt_pkg::*;
#(
    parameter int SEC_LEN = SEC_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Control
    input wire logic run,
    input wire logic clear,
    // Status
    output logic sec_tick,
    output logic half_sec,
    output logic sync_busy
);

    // ========================================================
    // Counter
    localparam logic [PRESC_W-1:0] LAST = PRESC_W'(SEC_LEN - 1);
    localparam logic [PRESC_W-1:0] HALF = PRESC_W'(SEC_LEN / 2);
    localparam logic [PRESC_W-1:0] WIN =
        PRESC_W'(SEC_LEN - SYNC_WINDOW_CYCLES);

    logic [PRESC_W-1:0] count, next_count;
    logic next_tick, next_half, next_busy;

    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (clear) begin
            next_count = '0;
        end else if (run) begin
            if (count == LAST) begin
                next_count = '0;
                next_tick = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
        next_half = next_count >= HALF;
        // Raised ahead of a rollover so a read cannot straddle it
        next_busy = run && !clear && next_count >= WIN;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
            sec_tick <= 1'b0;
            half_sec <= 1'b0;
            sync_busy <= 1'b0;
        end else begin
            count <= next_count;
            sec_tick <= next_tick;
            half_sec <= next_half;
            sync_busy <= next_busy;
        end
    end

endmodule

// ### verification/rtcdt_properties.sv
// Concurrent checks on the APB port of the calendar register block.
// Assumes it is bound to rtcdt_top and sees only that module's ports.
module rtcdt_checker
    import rtcdt_pkg::*;
#(
    parameter int SEC_LEN = SEC_CYCLES
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // APB request
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    // APB answer
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR
);
    // ========================================================
    // Helpers
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic rd_ack;
    logic mapped;
    assign rd_ack = PREADY && PSEL && PENABLE && !PWRITE;
    assign mapped = PADDR inside {OFS_CTRL, OFS_TIME, OFS_DATE,
        OFS_ALM_TIME, OFS_ALM_DATE, OFS_KEY};

    // ========================================================
    // Bus timing
    ready_after_setup_a: assert property (
        PSEL && !PENABLE |=> PREADY) else $error("no ready after setup");
    ready_single_a: assert property (
        PREADY |=> !PREADY) else $error("ready longer than one cycle");
    ready_cause_a: assert property (
        $rose(PREADY) |-> $past(PSEL && !PENABLE))
        else $error("ready without setup");
    unmapped_err_a: assert property (
        PREADY && PSEL |-> PSLVERR == !mapped)
        else $error("error response wrong for address");

    // ========================================================
    // Read-back field widths
    date_zero_bits_a: assert property (
        rd_ack && PADDR == OFS_DATE |-> (PRDATA & ~DATE_MASK) == 32'h0)
        else $error("date always-zero bits set");
    alm_time_bits_a: assert property (
        rd_ack && PADDR == OFS_ALM_TIME
        |-> (PRDATA & ~ALM_TIME_MASK) == 32'h0)
        else $error("alarm time always-zero bits set");
    alm_date_bits_a: assert property (
        rd_ack && PADDR == OFS_ALM_DATE
        |-> (PRDATA & ~ALM_DATE_MASK) == 32'h0)
        else $error("alarm date reserved bits set");
    key_read_zero_a: assert property (
        rd_ack && (PADDR == OFS_KEY || !mapped) |-> PRDATA == 32'h0)
        else $error("key or unmapped read not zero");
    sync_late_half_a: assert property (
        rd_ack && PADDR == OFS_CTRL && PRDATA[2]
        |-> PRDATA[15] && (PRDATA[1] || SEC_LEN < 64))
        else $error("sync status outside late half of running second");
endmodule

bind rtcdt_top rtcdt_checker #(.SEC_LEN(SEC_LEN)) i_chk (
    .CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR));

// ### verification/tb_rtcdt_top.sv
// Self-checking bench for the calendar register block.
// Assumes the bench is the only APB master; second shortened to 100 cycles.
module tb_rtcdt_top
    import rtcdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================
    // Signals
    localparam int SEC = 100;
    logic CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h00000000;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int n_compared = 0;
    // Date before and after one midnight: leap, plain, month, century
    logic [31:0] roll [5][2] = '{
        '{32'h24022803, 32'h24022904}, '{32'h23022806, 32'h23030100},
        '{32'h23043001, 32'h23050102}, '{32'h00022805, 32'h00022906},
        '{32'h99123102, 32'h00010103}};

    always #25 CLK = ~CLK;

    rtcdt_top #(.SEC_LEN(SEC)) i_dut (.CLK(CLK), .ARST_N(ARST_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR));

    // ========================================================
    // Tasks
    // Ready, read data and error are all taken at the rising edge
    // where ready is sampled high; only then is the request dropped.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK);
        while (PREADY !== 1'b1 && n < 20) begin
            n++;
            @(posedge CLK);
        end
        if (n >= 20) begin
            fails++;
            $display("[FAIL] %0t no ready from the slave", $time);
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic unlock(input logic [31:0] ctrl);
        xfer(1'b1, OFS_KEY, UNLOCK_KEY1);
        xfer(1'b1, OFS_KEY, UNLOCK_KEY2);
        xfer(1'b1, OFS_CTRL, ctrl);
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ========================================================
    // Tests
    initial begin
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        xfer(1'b0, OFS_DATE, 32'h0);
        check(rd, DATE_RESET);
        xfer(1'b1, OFS_DATE, 32'h12345601);
        xfer(1'b0, OFS_DATE, 32'h0);
        check(rd, DATE_RESET);
        $display("reset and lock test done");
        // Broken sequences: wrong key, then a foreign write in between
        xfer(1'b1, OFS_KEY, UNLOCK_KEY1);
        xfer(1'b1, OFS_KEY, 32'h12345678);
        xfer(1'b1, OFS_KEY, UNLOCK_KEY2);
        xfer(1'b1, OFS_CTRL, 32'h00000008);
        xfer(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        xfer(1'b1, OFS_KEY, UNLOCK_KEY1);
        xfer(1'b1, OFS_ALM_TIME, 32'h0);
        xfer(1'b1, OFS_KEY, UNLOCK_KEY2);
        xfer(1'b1, OFS_CTRL, 32'h00000008);
        xfer(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        unlock(32'h00000008);
        xfer(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h00000008);
        $display("unlock test done");
        xfer(1'b1, OFS_DATE, 32'hFFFFFF0F);
        xfer(1'b0, OFS_DATE, 32'h0);
        check(rd, DATE_MASK);
        xfer(1'b1, OFS_ALM_TIME, 32'hFFFFFF00);
        xfer(1'b0, OFS_ALM_TIME, 32'h0);
        check(rd, ALM_TIME_MASK);
        xfer(1'b1, OFS_ALM_DATE, 32'h00FFFF0F);
        xfer(1'b0, OFS_ALM_DATE, 32'h0);
        check(rd, ALM_DATE_MASK);
        xfer(1'b0, 8'h60, 32'h0);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h00000001);
        $display("field test done");
        for (int i = 0; i < 5; i++) begin
            unlock(32'h00008008);
            xfer(1'b1, OFS_TIME, 32'h23595900);
            xfer(1'b1, OFS_DATE, roll[i][0]);
            repeat (14) @(posedge CLK);
            xfer(1'b0, OFS_CTRL, 32'h0);
            check({rd[15], rd[3:1]}, 4'hC);
            repeat (33) @(posedge CLK);
            xfer(1'b0, OFS_CTRL, 32'h0);
            check({rd[15], rd[3:1]}, 4'hD);
            repeat (25) @(posedge CLK);
            xfer(1'b0, OFS_CTRL, 32'h0);
            check({rd[15], rd[3:1]}, 4'hF);
            repeat (30) @(posedge CLK);
            xfer(1'b0, OFS_DATE, 32'h0);
            check(rd, roll[i][1]);
            xfer(1'b0, OFS_TIME, 32'h0);
            check(rd, 32'h00000000);
        end
        $display("rollover test done");
        // Clearing the enable needs no key and locks the date again
        xfer(1'b1, OFS_CTRL, 32'h00008000);
        xfer(1'b1, OFS_DATE, 32'h12345601);
        xfer(1'b0, OFS_DATE, 32'h0);
        check(rd, roll[4][1]);
        $display("relock test done");
        wrap_up();
    end

    // ========================================================
    // Watchdog: the tests need under 1500 cycles
    initial begin
        repeat (5000) @(posedge CLK);
        fails++;
        wrap_up();
    end
endmodule
